// >>> core/dcbm_top.sv
// background test monitor for discrete channels with avalon-mm registers
//
// Local design decisions: the address map and the Avalon-MM register port.
`default_nettype none
module dcbm_top
	import dcbm_pkg::*;
#(
	parameter int unsigned TICK_CYC = TEST_INTERVAL_CYC
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// avalon-mm slave
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// channel pins
	input wire logic [NCH-1:0] CH_IN,
	input wire logic [NCH-1:0] CMP_IN,
	input wire logic [NCH-1:0] HI_CMP,
	input wire logic [NCH-1:0] LO_CMP,
	output logic [NCH-1:0] CH_OUT,
	output logic [NCH-1:0] CH_OE_N,
	// interrupt
	output logic IRQ
);
	// ====================================================================
	// state
	typedef struct packed {
		logic [NCH-1:0] ch_s1;
		logic [NCH-1:0] ch_s2;
		logic [NCH-1:0] cmp_s1;
		logic [NCH-1:0] cmp_s2;
		logic [NCH-1:0] hi_s1;
		logic [NCH-1:0] hi_s2;
		logic [NCH-1:0] lo_s1;
		logic [NCH-1:0] lo_s2;
		logic [NCH-1:0] deb_val;
		logic [NCH*16-1:0] deb_cnt;
		logic [NCH*CNT_W-1:0] fcnt;
		logic [NCH*4-1:0] oc_cnt;
		logic [31:0] tick_cnt;
		logic tick;
		logic en;
		logic [15:0] thresh_ms;
		logic [3:0] deb_sel;
		logic [NCH-1:0] dir_out;
		logic [NCH-1:0] out_val;
		logic [NCH-1:0] dyn;
		logic [NCH-1:0] lat;
		logic [NCH-1:0] mask;
		logic [NCH-1:0] oc_lat;
		logic [NCH-1:0] oc_mask;
		logic [NCH-1:0] trip;
		logic [NCH-1:0] rise;
		logic [NCH-1:0] fall;
		logic [NCH-1:0] above;
		logic [NCH-1:0] below;
		logic [NCH-1:0] mid;
		logic ack;
		logic [31:0] rdata;
		logic irq;
	} dcbm_state_t;

	dcbm_state_t st_r;
	dcbm_state_t st_nxt;

	// debounce delay: 2^sel cycles, zero means none
	function automatic logic [15:0] deb_len(input logic [3:0] sel);
		deb_len = (sel == 4'h0) ? 16'h0000 : (16'h0001 << sel);
	endfunction : deb_len

	function automatic logic [NCH-1:0] w1c(input logic [NCH-1:0] cur,
		input logic [NCH-1:0] set, input logic [NCH-1:0] clr);
		w1c = (cur & ~clr) | set;
	endfunction : w1c

	logic [CNT_W-1:0] thresh_cnt;
	logic [NCH-1:0] eff_data;
	logic [NCH-1:0] oc_now;
	logic [NCH-1:0] fault_now;
	logic [NCH-1:0] new_dyn;
	logic [NCH-1:0] new_rise;
	logic [NCH-1:0] new_fall;
	logic [NCH-1:0] new_oc;
	logic [NCH-1:0] lat_set;
	logic wr_acc;
	logic rd_acc;

	// ms threshold to interval count
	assign thresh_cnt = CNT_W'((32'(st_r.thresh_ms) * 1000) / TEST_INTERVAL_US);

	// ====================================================================
	// next state
	always_comb begin
		logic [15:0] dc;
		logic [CNT_W-1:0] fc;
		logic [3:0] oc;
		st_nxt = st_r;
		dc = '0;
		fc = '0;
		oc = '0;
		// writes land only on the edge that ends the wait
		wr_acc = AVS_WRITE && st_r.ack;
		rd_acc = AVS_READ && !st_r.ack;
		st_nxt.ch_s1 = CH_IN;
		st_nxt.ch_s2 = st_r.ch_s1;
		st_nxt.cmp_s1 = CMP_IN;
		st_nxt.cmp_s2 = st_r.cmp_s1;
		st_nxt.hi_s1 = HI_CMP;
		st_nxt.hi_s2 = st_r.hi_s1;
		st_nxt.lo_s1 = LO_CMP;
		st_nxt.lo_s2 = st_r.lo_s1;
		// interval tick
		st_nxt.tick = 1'b0;
		if (st_r.tick_cnt >= TICK_CYC - 1) begin
			st_nxt.tick_cnt = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
		end
		new_dyn = st_r.dyn;
		new_rise = '0;
		new_fall = '0;
		new_oc = '0;
		for (int i = 0; i < NCH; i++) begin
			// debounce
			dc = st_r.deb_cnt[i*16 +: 16];
			if (st_r.ch_s2[i] == st_r.deb_val[i]) begin
				dc = '0;
			end else if (dc >= deb_len(st_r.deb_sel)) begin
				st_nxt.deb_val[i] = st_r.ch_s2[i];
				new_rise[i] = st_r.ch_s2[i];
				new_fall[i] = !st_r.ch_s2[i];
				dc = '0;
			end else begin
				dc = dc + 16'h1;
			end
			st_nxt.deb_cnt[i*16 +: 16] = dc;
			fc = st_r.fcnt[i*CNT_W +: CNT_W];
			oc = st_r.oc_cnt[i*4 +: 4];
			if (st_r.tick && st_r.en) begin
				if (fault_now[i]) begin
					fc = (fc > {CNT_W{1'b1}} - CNT_W'(2)) ? {CNT_W{1'b1}} : fc + CNT_W'(2);
				end else if (fc != '0) begin
					fc = fc - CNT_W'(1);
				end
				new_dyn[i] = fc > thresh_cnt;
				if (oc_now[i] && !st_r.trip[i]) begin
					if (oc >= 4'(OC_STAB_INTERVALS)) begin
						new_oc[i] = 1'b1;
					end else begin
						oc = oc + 4'h1;
					end
				end else begin
					oc = '0;
				end
			end
			st_nxt.fcnt[i*CNT_W +: CNT_W] = fc;
			st_nxt.oc_cnt[i*4 +: 4] = oc;
		end
		if (!st_r.en) begin
			new_dyn = '0;
		end
		st_nxt.dyn = new_dyn;
		lat_set = new_dyn & ~st_r.dyn;
		st_nxt.above = st_r.hi_s2;
		st_nxt.below = st_r.lo_s2;
		st_nxt.mid = ~st_r.hi_s2 & ~st_r.lo_s2;
		// register writes; hardware sets win over clears
		st_nxt.lat = w1c(st_r.lat, lat_set, '0);
		st_nxt.oc_lat = w1c(st_r.oc_lat, new_oc, '0);
		st_nxt.rise = w1c(st_r.rise, new_rise, '0);
		st_nxt.fall = w1c(st_r.fall, new_fall, '0);
		st_nxt.trip = st_r.trip | new_oc;
		if (wr_acc) begin
			unique case (AVS_ADDRESS)
				A_CTRL: st_nxt.en = AVS_WRITEDATA[CTRL_EN_BIT];
				A_THRESH_MS: st_nxt.thresh_ms = AVS_WRITEDATA[15:0];
				A_DIR: st_nxt.dir_out = AVS_WRITEDATA[NCH-1:0];
				A_OUT: st_nxt.out_val = AVS_WRITEDATA[NCH-1:0];
				A_DEB: st_nxt.deb_sel = AVS_WRITEDATA[3:0];
				A_LAT: st_nxt.lat = w1c(st_r.lat, lat_set, AVS_WRITEDATA[NCH-1:0]);
				A_MASK: st_nxt.mask = AVS_WRITEDATA[NCH-1:0];
				A_OC_LAT: begin
					// only untripped channels may clear
					st_nxt.oc_lat = w1c(st_r.oc_lat, new_oc,
						AVS_WRITEDATA[NCH-1:0] & ~st_r.trip);
				end
				A_OC_MASK: st_nxt.oc_mask = AVS_WRITEDATA[NCH-1:0];
				A_OC_RESET: st_nxt.trip = (st_r.trip & ~AVS_WRITEDATA[NCH-1:0]) | new_oc;
				A_RISE: st_nxt.rise = w1c(st_r.rise, new_rise, AVS_WRITEDATA[NCH-1:0]);
				A_FALL: st_nxt.fall = w1c(st_r.fall, new_fall, AVS_WRITEDATA[NCH-1:0]);
				default: ;
			endcase
		end
		// one wait cycle then ack
		st_nxt.ack = (AVS_READ || AVS_WRITE) && !st_r.ack;
		st_nxt.rdata = st_r.rdata;
		if (rd_acc) begin
			unique case (AVS_ADDRESS)
				A_CTRL: st_nxt.rdata = 32'(st_r.en);
				A_THRESH_MS: st_nxt.rdata = 32'(st_r.thresh_ms);
				A_DIR: st_nxt.rdata = 32'(st_r.dir_out);
				A_OUT: st_nxt.rdata = 32'(st_r.out_val);
				A_DEB: st_nxt.rdata = 32'(st_r.deb_sel);
				A_DYN: st_nxt.rdata = 32'(st_r.dyn);
				A_LAT: st_nxt.rdata = 32'(st_r.lat);
				A_MASK: st_nxt.rdata = 32'(st_r.mask);
				A_OC_LAT: st_nxt.rdata = 32'(st_r.oc_lat);
				A_OC_MASK: st_nxt.rdata = 32'(st_r.oc_mask);
				A_RISE: st_nxt.rdata = 32'(st_r.rise);
				A_FALL: st_nxt.rdata = 32'(st_r.fall);
				A_ABOVE: st_nxt.rdata = 32'(st_r.above);
				A_BELOW: st_nxt.rdata = 32'(st_r.below);
				A_MID: st_nxt.rdata = 32'(st_r.mid);
				A_INPUT: st_nxt.rdata = 32'(st_r.deb_val);
				A_TRIP: st_nxt.rdata = 32'(st_r.trip);
				default: st_nxt.rdata = UNMAPPED_DATA;
			endcase
		end
		st_nxt.irq = |((st_r.lat & st_r.mask) | (st_r.oc_lat & st_r.oc_mask));
	end

	// ====================================================================
	// comparator and overcurrent inference
	// driven channels check commanded level, inputs check read level
	assign eff_data = (st_r.dir_out & ~st_r.trip & st_r.out_val)
		| (~(st_r.dir_out & ~st_r.trip) & st_r.ch_s2);
	assign fault_now = eff_data ^ st_r.cmp_s2;
	assign oc_now = st_r.dir_out & ~st_r.trip & (st_r.out_val ^ st_r.ch_s2);

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_r <= '0;
			st_r.thresh_ms <= THRESH_RST;
			st_r.deb_sel <= DEB_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ====================================================================
	// outputs
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !st_r.ack;
	assign AVS_READDATA = st_r.rdata;
	assign CH_OUT = st_r.out_val;
	assign CH_OE_N = ~(st_r.dir_out & ~st_r.trip);
	assign IRQ = st_r.irq;

	// ====================================================================
	// assertions
	property p_cnt_add2;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.tick && st_r.en && fault_now[0] && st_r.fcnt[CNT_W-1:0] < 16'h00FF)
		|=> st_r.fcnt[CNT_W-1:0] == $past(st_r.fcnt[CNT_W-1:0]) + 16'h2;
	endproperty
	a_cnt_add2: assert property (p_cnt_add2) else $error("counter did not add two");

	property p_cnt_sub1;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.tick && st_r.en && !fault_now[0])
		|=> st_r.fcnt[CNT_W-1:0] == (($past(st_r.fcnt[CNT_W-1:0]) == 16'h0)
			? 16'h0 : $past(st_r.fcnt[CNT_W-1:0]) - 16'h1);
	endproperty
	a_cnt_sub1: assert property (p_cnt_sub1) else $error("counter did not subtract one");

	property p_dyn_thr;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.en && $past(st_r.tick)) |-> st_r.dyn[0] == (st_r.fcnt[CNT_W-1:0] > thresh_cnt);
	endproperty
	a_dyn_thr: assert property (p_dyn_thr) else $error("dynamic fault wrong");

	property p_lat_hold;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.lat[0] && !(wr_acc && AVS_ADDRESS == A_LAT && AVS_WRITEDATA[0])) |=> st_r.lat[0];
	endproperty
	a_lat_hold: assert property (p_lat_hold) else $error("latched fault lost");

	property p_irq;
		@(posedge CLOCK) disable iff (!RESET_N)
		(|((st_r.lat & st_r.mask) | (st_r.oc_lat & st_r.oc_mask))) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	property p_irq_off;
		@(posedge CLOCK) disable iff (!RESET_N)
		!(|((st_r.lat & st_r.mask) | (st_r.oc_lat & st_r.oc_mask))) |=> !IRQ;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

	property p_off;
		@(posedge CLOCK) disable iff (!RESET_N)
		!st_r.en |=> st_r.fcnt == $past(st_r.fcnt);
	endproperty
	a_off: assert property (p_off) else $error("test ran while disabled");

	property p_trip_in;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.trip & ~CH_OE_N) == '0;
	endproperty
	a_trip_in: assert property (p_trip_in) else $error("tripped channel still driven");

	property p_oc_reset;
		@(posedge CLOCK) disable iff (!RESET_N)
		(wr_acc && AVS_ADDRESS == A_OC_RESET)
		|=> (st_r.trip & $past(AVS_WRITEDATA[NCH-1:0]) & ~$past(new_oc)) == '0
			&& st_r.oc_mask == $past(st_r.oc_mask);
	endproperty
	a_oc_reset: assert property (p_oc_reset) else $error("overcurrent reset failed");

	property p_wait;
		@(posedge CLOCK) disable iff (!RESET_N)
		(AVS_READ || AVS_WRITE) |-> ##[0:1] !AVS_WAITREQUEST;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");

	property p_lat_set;
		@(posedge CLOCK) disable iff (!RESET_N)
		$rose(st_r.dyn[0]) |-> st_r.lat[0];
	endproperty
	a_lat_set: assert property (p_lat_set) else $error("new fault not latched");

	property p_dyn_off;
		@(posedge CLOCK) disable iff (!RESET_N)
		!st_r.en |=> st_r.dyn == '0;
	endproperty
	a_dyn_off: assert property (p_dyn_off) else $error("dynamic fault while disabled");

	property p_rise;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.deb_sel == '0 && st_r.ch_s2[1] && !st_r.deb_val[1])
		|=> st_r.rise[1] && st_r.deb_val[1];
	endproperty
	a_rise: assert property (p_rise) else $error("rising transition missed");

	property p_fall;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.deb_sel == '0 && !st_r.ch_s2[1] && st_r.deb_val[1])
		|=> st_r.fall[1] && !st_r.deb_val[1];
	endproperty
	a_fall: assert property (p_fall) else $error("falling transition missed");

	property p_deb_hold;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.deb_sel != '0 && st_r.ch_s2[5] != st_r.deb_val[5]
			&& st_r.deb_cnt[5*16 +: 16] == '0)
		|=> st_r.deb_val[5] == $past(st_r.deb_val[5]);
	endproperty
	a_deb_hold: assert property (p_deb_hold) else $error("input changed without debounce");

	property p_oc_trip;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.tick && st_r.en && oc_now[2] && st_r.oc_cnt[2*4 +: 4] >= 4'(OC_STAB_INTERVALS))
		|=> st_r.trip[2] && CH_OE_N[2];
	endproperty
	a_oc_trip: assert property (p_oc_trip) else $error("overcurrent did not trip");

	property p_oc_hold;
		@(posedge CLOCK) disable iff (!RESET_N)
		(st_r.trip[2] && st_r.oc_lat[2]) |=> st_r.oc_lat[2];
	endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("overcurrent cleared while tripped");

	property p_oc_mask_sep;
		@(posedge CLOCK) disable iff (!RESET_N)
		(wr_acc && AVS_ADDRESS == A_OC_MASK)
		|=> st_r.trip == ($past(st_r.trip) | $past(new_oc));
	endproperty
	a_oc_mask_sep: assert property (p_oc_mask_sep) else $error("mask write moved trip");

	property p_one_wait;
		@(posedge CLOCK) disable iff (!RESET_N)
		((AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST)
		|=> !(AVS_READ || AVS_WRITE) || AVS_WAITREQUEST;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("second answer without wait");

	property p_wr_late;
		@(posedge CLOCK) disable iff (!RESET_N)
		(AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == A_MASK)
		|=> st_r.mask == $past(st_r.mask);
	endproperty
	a_wr_late: assert property (p_wr_late) else $error("write landed during wait");
endmodule : dcbm_top
`default_nettype wire

// >>> core/dcbm_pkg.sv
// constants for the discrete channel background test monitor
// ====================================================================
// Operation
// - compare channel data against independent test comparator
// - fault interval adds two to counter
// - clean interval subtracts one, floor zero
// - counter above threshold sets fault bit
// - threshold given in ms, converted to count
// - dynamic and latched fault status per channel
// - unmasked failure raises interrupt request
// - host enables background testing; runs only then
// - rising and falling transitions flagged separately
// - output mismatch with readback infers overcurrent
// - persistent overcurrent returns channel to input
// - host reset command restores drive; oc_lat needs its own clear
// - overcurrent reset independent of interrupt enable
// - report above-high, below-low, mid-range band
// - input debounce with selectable delay
`default_nettype none
package dcbm_pkg;
	localparam int unsigned NCH = 16;
	localparam int unsigned CLK_HZ = 50000000;
	// test interval in microseconds, cycles derived
	localparam int unsigned TEST_INTERVAL_US = 1000;
	localparam int unsigned TEST_INTERVAL_CYC = TEST_INTERVAL_US * (CLK_HZ / 1000000);
	// overcurrent stabilization time in microseconds
	localparam int unsigned OC_STAB_US = 2000;
	localparam int unsigned OC_STAB_INTERVALS = (OC_STAB_US + TEST_INTERVAL_US - 1) / TEST_INTERVAL_US;
	localparam int unsigned CNT_W = 16;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_THRESH_MS = 8'h04;
	localparam logic [7:0] A_DIR = 8'h08;
	localparam logic [7:0] A_OUT = 8'h0C;
	localparam logic [7:0] A_DEB = 8'h10;
	localparam logic [7:0] A_DYN = 8'h14;
	localparam logic [7:0] A_LAT = 8'h18;
	localparam logic [7:0] A_MASK = 8'h1C;
	localparam logic [7:0] A_OC_LAT = 8'h20;
	localparam logic [7:0] A_OC_MASK = 8'h24;
	localparam logic [7:0] A_OC_RESET = 8'h28;
	localparam logic [7:0] A_RISE = 8'h2C;
	localparam logic [7:0] A_FALL = 8'h30;
	localparam logic [7:0] A_ABOVE = 8'h34;
	localparam logic [7:0] A_BELOW = 8'h38;
	localparam logic [7:0] A_MID = 8'h3C;
	localparam logic [7:0] A_INPUT = 8'h40;
	localparam logic [7:0] A_TRIP = 8'h44;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam logic [15:0] THRESH_RST = 16'h000A;
	localparam logic [3:0] DEB_RST = 4'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : dcbm_pkg
`default_nettype wire

// >>> test/dcbm_field.sv
// field wiring model on the channel pins
`default_nettype none
module dcbm_field
	import dcbm_pkg::*;
(
	// from the device
	input wire logic [NCH-1:0] drv,
	input wire logic [NCH-1:0] drv_oe_n,
	// test controls
	input wire logic [NCH-1:0] ext,
	input wire logic [NCH-1:0] short_m,
	input wire logic [NCH-1:0] cmp_bad,
	// to the device
	output logic [NCH-1:0] rd,
	output logic [NCH-1:0] cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// wiring
	// shorted pin reads back the opposite level
	assign rd = (~drv_oe_n & (drv ^ short_m)) | (drv_oe_n & ext);
	// comparator disagrees only where told
	assign cmp = rd ^ cmp_bad;
endmodule : dcbm_field
`default_nettype wire

// >>> test/test_discrete_channel_bit_monitor.sv
// self-checking bench for the channel background test monitor
`default_nettype none
module test_discrete_channel_bit_monitor
	import dcbm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// signals and instances
	logic clock, reset_n, rd_s, wr_s, wait_r, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [NCH-1:0] ext, short_m, cmp_bad, hi, lo, ch_in, cmp_in, ch_out, oe_n;
	int fail_count, samples_checked, cyc;
	dcbm_top #(.TICK_CYC(20)) dcbm_top_inst (.CLOCK(clock), .RESET_N(reset_n),
		.AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r), .CH_IN(ch_in), .CMP_IN(cmp_in),
		.HI_CMP(hi), .LO_CMP(lo), .CH_OUT(ch_out), .CH_OE_N(oe_n), .IRQ(irq));
	dcbm_field dcbm_field_inst (.drv(ch_out), .drv_oe_n(oe_n), .ext(ext),
		.short_m(short_m), .cmp_bad(cmp_bad), .rd(ch_in), .cmp(cmp_in));
	// ==========================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= w;
		rd_s <= ~w;
		do @(posedge clock); while (wait_r !== 1'b0);
		q = rdata;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
	endtask : waitc
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results
	// ==========================================
	// scenarios
	task automatic t_reset;
		bus(0, A_THRESH_MS, 0);
		chk("thresh", q, {16'h0000, THRESH_RST});
		bus(0, 8'hFC, 0);
		chk("unmapped", q, UNMAPPED_DATA);
		chk("oe_n", {16'h0000, oe_n}, 32'h0000_FFFF);
		chk("irq", {31'h0, irq}, 32'h0);
	endtask : t_reset
	task automatic t_off;
		cmp_bad <= 16'h0001;
		waitc(100);
		bus(0, A_LAT, 0);
		chk("lat off", q, 32'h0);
		cmp_bad <= 16'h0000;
	endtask : t_off
	task automatic t_filter;
		bus(1, A_THRESH_MS, 2);
		bus(1, A_CTRL, 1);
		cmp_bad <= 16'h0001;
		bus(0, A_DYN, 0);
		chk("dyn early", q & 32'h1, 32'h0);
		waitc(100);
		bus(0, A_DYN, 0);
		chk("dyn set", q & 32'h1, 32'h1);
		cmp_bad <= 16'h0000;
		waitc(20);
		bus(0, A_DYN, 0);
		chk("dyn slow", q & 32'h1, 32'h1);
		waitc(300);
		bus(0, A_DYN, 0);
		chk("dyn clr", q & 32'h1, 32'h0);
		bus(0, A_LAT, 0);
		chk("lat held", q & 32'h1, 32'h1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		bus(1, A_MASK, 1);
		waitc(3);
		chk("irq on", {31'h0, irq}, 32'h1);
		cmp_bad <= 16'h0001;
		waitc(50);
		bus(0, A_DYN, 0);
		chk("floor", q & 32'h1, 32'h1);
		cmp_bad <= 16'h0000;
		waitc(250);
		bus(1, A_LAT, 1);
		bus(0, A_LAT, 0);
		chk("lat w1c", q & 32'h1, 32'h0);
		waitc(3);
		chk("irq off", {31'h0, irq}, 32'h0);
	endtask : t_filter
	task automatic t_edge;
		bus(1, A_RISE, 32'hFFFF);
		bus(1, A_FALL, 32'hFFFF);
		ext <= 16'h0002;
		waitc(6);
		bus(0, A_RISE, 0);
		chk("rise", q & 32'h2, 32'h2);
		bus(0, A_FALL, 0);
		chk("no fall", q & 32'h2, 32'h0);
		ext <= 16'h0000;
		waitc(6);
		bus(0, A_FALL, 0);
		chk("fall", q & 32'h2, 32'h2);
	endtask : t_edge
	task automatic t_band;
		hi <= 16'h0008;
		lo <= 16'h0010;
		waitc(4);
		bus(0, A_ABOVE, 0);
		chk("above", q, 32'h0008);
		bus(0, A_BELOW, 0);
		chk("below", q, 32'h0010);
		bus(0, A_MID, 0);
		chk("mid", q, 32'hFFE7);
	endtask : t_band
	task automatic t_deb;
		bus(1, A_DEB, 3);
		ext <= 16'h0020;
		waitc(2);
		ext <= 16'h0000;
		waitc(30);
		bus(0, A_INPUT, 0);
		chk("bounce", q & 32'h20, 32'h0);
		ext <= 16'h0020;
		waitc(30);
		bus(0, A_INPUT, 0);
		chk("settled", q & 32'h20, 32'h20);
		ext <= 16'h0000;
		bus(1, A_DEB, 0);
	endtask : t_deb
	task automatic t_oc;
		bus(1, A_OC_MASK, 4);
		bus(1, A_DIR, 4);
		bus(1, A_OUT, 4);
		chk("ch out", {31'h0, ch_out[2]}, 32'h1);
		short_m <= 16'h0004;
		waitc(10);
		chk("oe early", {31'h0, oe_n[2]}, 32'h0);
		waitc(100);
		chk("oe trip", {31'h0, oe_n[2]}, 32'h1);
		bus(0, A_TRIP, 0);
		chk("trip", q & 32'h4, 32'h4);
		bus(1, A_OC_LAT, 4);
		bus(0, A_OC_LAT, 0);
		chk("oc held", q & 32'h4, 32'h4);
		chk("oc irq", {31'h0, irq}, 32'h1);
		short_m <= 16'h0000;
		bus(1, A_OC_RESET, 4);
		waitc(3);
		chk("oe back", {31'h0, oe_n[2]}, 32'h0);
		bus(0, A_OC_MASK, 0);
		chk("oc mask", q, 32'h4);
		bus(1, A_OC_LAT, 4);
		bus(0, A_OC_LAT, 0);
		chk("oc clr", q & 32'h4, 32'h0);
	endtask : t_oc
	// ==========================================
	// clock, timeout and main sequence
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		{reset_n, rd_s, wr_s, addr, wdata} = '0;
		{ext, short_m, cmp_bad, hi, lo} = '0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_off();
		t_filter();
		t_edge();
		t_band();
		t_deb();
		t_oc();
		results();
	end
endmodule : test_discrete_channel_bit_monitor
`default_nettype wire
